//--- shared/axis_pos_params.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * axis position logic. Assumes a 50 MHz pclk and a 32-bit APB register bus.
 */
`ifndef AXIS_POS_PARAMS_SVH
`define AXIS_POS_PARAMS_SVH

`define REG_CTRL 8'h00
`define REG_AXIS_CFG 8'h04
`define REG_HOME_PRESET 8'h08
`define REG_HOME_OFFSET 8'h0C
`define REG_LEN_CORR 8'h10
`define REG_SOFT_LIM 8'h14
`define REG_TARGET 8'h18
`define REG_CUR_POS 8'h1C
`define REG_STATUS 8'h20
`define REG_ZONE_BASE 8'h40
`define REG_ZONE_END 8'h80

`define CTRL_HOME_BIT 0
`define CTRL_MOVE_BIT 1
`define CFG_AXIS_TYPE_BIT 0
`define CFG_ROT_MODE_LSB 1
`define CFG_SHORTCUT_LSB 4
`define CFG_INF_STROKE_BIT 7

`define RST_HOME_PRESET 32'h0000_0000
`define RST_HOME_OFFSET 32'h0000_03E8
`define RST_LEN_CORR 32'h0000_0000
`define RST_SOFT_LIM 32'h05F5_E0FF

`define ROT_MODE_INDEX 3'h1
`define SEL_MAX 3'h5
`define SHORTCUT_ON 3'h1
`define INDEX_LIMIT 32'h0005_7E3F
`define REV_UNITS 32'h0005_7E40
`define HALF_REV 32'h0002_BF20
`define LEN_CORR_SCALE 64'h0000_0000_000F_4240

`define CLK_PERIOD_NS 20
`define STEP_PERIOD_NS 1000
`define STEP_CYCLES ((`STEP_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define ZONE_COUNT 4
`define ZONE_PORTS 900

`endif

//--- shared/axis_pos_pkg.sv
/*
 * Types shared by the axis position logic and its zone comparator.
 * Assumes axis_pos_params.svh is on the include path.
 */
`include "axis_pos_params.svh"

package axis_pos_pkg;

    typedef enum logic [1:0] {S_IDLE, S_SEEK, S_HOFS, S_MOVE} mode_t;

    typedef struct packed {
        logic signed [31:0] max;
        logic signed [31:0] min;
        logic [9:0] port;
    } zone_cfg_t;

    typedef struct packed {
        logic axis_type;
        logic [2:0] rot_mode;
        logic [2:0] shortcut;
        logic inf_stroke;
    } axis_cfg_t;

    typedef struct packed {
        mode_t mode;
        axis_cfg_t cfg;
        logic signed [31:0] home_preset;
        logic signed [31:0] home_offset;
        logic signed [31:0] len_corr;
        logic signed [31:0] soft_lim;
        logic signed [31:0] target;
        logic signed [31:0] cur_pos;
        logic signed [31:0] move_delta;
        logic [31:0] remain;
        logic [15:0] tick;
        logic step_dir;
        logic step;
        logic homed;
        logic move_err;
        logic [31:0] rdata;
        zone_cfg_t [`ZONE_COUNT-1:0] zones;
    } axis_state_t;

    typedef struct packed {
        logic [`ZONE_COUNT-1:0] hit;
        logic [`ZONE_PORTS-1:0] port;
        logic [`ZONE_PORTS-1:0] rsv;
    } zone_state_t;

endpackage

//--- hdl/zone_compare.sv
/*
 * Zone comparator: flags each zone that holds the current position and
 * maps the hits onto the output port / flag space.
 * Assumes position and zone settings are synchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "axis_pos_params.svh"

module zone_compare
    import axis_pos_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic signed [31:0] position,
    input wire zone_cfg_t [`ZONE_COUNT-1:0] zones,
    output logic [`ZONE_COUNT-1:0] zone_hit,
    output logic [`ZONE_PORTS-1:0] zone_port,
    output logic [`ZONE_PORTS-1:0] port_reserved
);
    localparam logic [9:0] NPORT = 10'(`ZONE_PORTS);

    zone_state_t st_ff;
    zone_state_t nxt_st;
    logic [`ZONE_COUNT-1:0] inside_now;

    function automatic logic in_zone(input logic signed [31:0] p, input zone_cfg_t z);
        in_zone = (p >= z.min) && (p <= z.max);
    endfunction

    always_comb begin
        nxt_st = '0;
        inside_now = '0;
        for (int z = 0; z < `ZONE_COUNT; z++) begin
            inside_now[z] = in_zone(position, zones[z]);
            nxt_st.hit[z] = inside_now[z];
            if (zones[z].port < NPORT) begin
                nxt_st.rsv[zones[z].port] = 1'b1;
                if (inside_now[z]) begin
                    nxt_st.port[zones[z].port] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign zone_hit = st_ff.hit;
    assign zone_port = st_ff.port;
    assign port_reserved = st_ff.rsv;

    a_zone_follow: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> st_ff.hit == $past(inside_now) &&
            st_ff.hit[0] == ($past(position) >= $past(zones[0].min) &&
            $past(position) <= $past(zones[0].max)))
        else $error("zone hit does not follow position");

    a_port_drive: assert property (@(posedge pclk) disable iff (!presetn)
        (inside_now[0] && zones[0].port < NPORT) |=> st_ff.port[$past(zones[0].port)])
        else $error("zone port not driven on hit");

endmodule

`default_nettype wire

//--- hdl/axis_home_zone_position_logic.sv
/*
 * Per-axis position logic: home search with index offset and preset,
 * length-corrected moves, linear / rotational modes with short-cut path,
 * and four position zones driving output ports. APB register slave.
 * Assumes all inputs synchronous to pclk; enc_index is a one-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none
`include "axis_pos_params.svh"

// What this block does
// - at home load current position with preset
// - after index pulse travel signed offset, then home
// - scale travel by correction per metre
// - axis type 0 linear, 1 rotational
// - rotational mode 0 normal, 1 index
// - rotational axis forces index mode
// - index mode soft limit fixed 359.999
// - absolute unit linear refuses infinite stroke
// - absolute unit rotational axis refuses short-cut
// - short-cut takes nearest path on rotation
// - short-cut 0 off, 1 on, 2-5 reserved
// - drive zone output while position in zone
// - zone limits signed, reset to zero
// - zone output number 0-899, reserved from programs
// - four independent zones per axis
module axis_home_zone_position_logic
    import axis_pos_pkg::*;
#(
    parameter int STEP_CYC = `STEP_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic abs_unit_fitted,
    input wire logic enc_index,
    output logic step_pulse,
    output logic step_dir,
    output logic signed [31:0] cur_position,
    output logic homed,
    output logic busy,
    output logic [`ZONE_COUNT-1:0] zone_hit,
    output logic [`ZONE_PORTS-1:0] zone_port,
    output logic [`ZONE_PORTS-1:0] zone_port_reserved
);
    localparam logic signed [31:0] LIMIT = `INDEX_LIMIT;
    localparam logic signed [31:0] REV = `REV_UNITS;
    localparam logic signed [31:0] HALF = `HALF_REV;
    localparam logic signed [63:0] LEN_SCALE = `LEN_CORR_SCALE;
    localparam logic [15:0] TICK_LAST = 16'(STEP_CYC - 1);

    axis_state_t st_ff;
    axis_state_t nxt_st;
    zone_cfg_t [`ZONE_COUNT-1:0] zone_cfg;

    logic setup;
    logic wr;
    logic idx_mode;
    logic rot_axis;
    logic shortcut_eff;
    logic inf_eff;
    logic signed [31:0] soft_lim_eff;
    logic step_now;
    logic home_req;
    logic move_req;
    logic move_ok;
    logic move_start;
    logic signed [31:0] path_d;
    logic signed [31:0] corr_d;
    logic [31:0] rd;

    function automatic logic [31:0] mag(input logic signed [31:0] v);
        mag = v[31] ? 32'(-v) : 32'(v);
    endfunction

    // travel plus correction in thousandths of a millimetre per metre
    function automatic logic signed [31:0] corrected(input logic signed [31:0] d,
                                                     input logic signed [31:0] lc);
        logic signed [63:0] prod;
        prod = 64'(d) * 64'(lc);
        corrected = 32'(64'(d) + prod / LEN_SCALE);
    endfunction

    function automatic logic signed [31:0] path_delta(input logic signed [31:0] tgt,
                                                      input logic signed [31:0] cur,
                                                      input logic wrap);
        logic signed [31:0] d;
        d = tgt - cur;
        if (wrap) begin
            if (d > HALF) begin
                d = d - REV;
            end else if (d < -HALF) begin
                d = d + REV;
            end
        end
        path_delta = d;
    endfunction

    function automatic logic signed [31:0] step_pos(input logic signed [31:0] p,
                                                    input logic up,
                                                    input logic wrap);
        if (up) begin
            step_pos = (wrap && p >= LIMIT) ? 32'sh0000_0000 : p + 32'sh0000_0001;
        end else begin
            step_pos = (wrap && p <= 32'sh0000_0000) ? LIMIT : p - 32'sh0000_0001;
        end
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        logic word;
        word = (a[1:0] == 2'h0);
        mapped = word && ((a <= `REG_STATUS) ||
                          (a >= `REG_ZONE_BASE && a < `REG_ZONE_END && a[3:2] != 2'h3));
    endfunction

    // effective configuration after the absolute-unit refusals
    always_comb begin
        rot_axis = st_ff.cfg.axis_type;
        idx_mode = rot_axis || (st_ff.cfg.rot_mode == `ROT_MODE_INDEX);
        soft_lim_eff = idx_mode ? LIMIT : st_ff.soft_lim;
        shortcut_eff = (st_ff.cfg.shortcut == `SHORTCUT_ON) &&
                       !(abs_unit_fitted && rot_axis && idx_mode);
        inf_eff = st_ff.cfg.inf_stroke && !(abs_unit_fitted && !rot_axis);
    end

    always_comb begin
        for (int z = 0; z < `ZONE_COUNT; z++) begin
            zone_cfg[z] = st_ff.zones[z];
        end
    end

    always_comb begin
        rd = 32'h0000_0000;
        if (paddr >= `REG_ZONE_BASE && paddr < `REG_ZONE_END) begin
            unique case (paddr[3:2])
                2'h0: rd = st_ff.zones[paddr[5:4]].max;
                2'h1: rd = st_ff.zones[paddr[5:4]].min;
                2'h2: rd = {22'h0, st_ff.zones[paddr[5:4]].port};
                2'h3: rd = 32'h0000_0000;
            endcase
        end else begin
            case (paddr)
                `REG_AXIS_CFG: rd = {24'h0, inf_eff, 3'(shortcut_eff ? `SHORTCUT_ON : 3'h0),
                                     idx_mode ? `ROT_MODE_INDEX : st_ff.cfg.rot_mode,
                                     rot_axis};
                `REG_HOME_PRESET: rd = st_ff.home_preset;
                `REG_HOME_OFFSET: rd = st_ff.home_offset;
                `REG_LEN_CORR: rd = st_ff.len_corr;
                `REG_SOFT_LIM: rd = soft_lim_eff;
                `REG_TARGET: rd = st_ff.target;
                `REG_CUR_POS: rd = st_ff.cur_pos;
                `REG_STATUS: rd = {20'h0, zone_hit, 2'h0, inf_eff, shortcut_eff,
                                   idx_mode, st_ff.move_err, busy, st_ff.homed};
                default: rd = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        setup = psel && !penable;
        wr = psel && penable && pwrite && mapped(paddr);
        home_req = wr && paddr == `REG_CTRL && pwdata[`CTRL_HOME_BIT];
        move_req = wr && paddr == `REG_CTRL && pwdata[`CTRL_MOVE_BIT] && !home_req;
        step_now = (st_ff.tick == TICK_LAST);
        path_d = path_delta(st_ff.target, st_ff.cur_pos, rot_axis && shortcut_eff);
        corr_d = corrected(path_d, st_ff.len_corr);
        if (idx_mode) begin
            move_ok = st_ff.target >= 32'sh0000_0000 && st_ff.target <= LIMIT;
        end else begin
            move_ok = inf_eff || st_ff.target <= soft_lim_eff;
        end
        move_start = move_req && st_ff.mode == S_IDLE && st_ff.homed && move_ok;

        nxt_st = st_ff;
        nxt_st.step = 1'b0;
        if (setup) begin
            nxt_st.rdata = rd;
        end
        if (wr) begin
            if (paddr >= `REG_ZONE_BASE) begin
                unique case (paddr[3:2])
                    2'h0: nxt_st.zones[paddr[5:4]].max = pwdata;
                    2'h1: nxt_st.zones[paddr[5:4]].min = pwdata;
                    2'h2: nxt_st.zones[paddr[5:4]].port = pwdata[9:0];
                    2'h3: nxt_st.zones[paddr[5:4]].port = st_ff.zones[paddr[5:4]].port;
                endcase
            end else begin
                case (paddr)
                    `REG_AXIS_CFG: begin
                        nxt_st.cfg.axis_type = pwdata[`CFG_AXIS_TYPE_BIT];
                        if (pwdata[`CFG_ROT_MODE_LSB +: 3] <= `SEL_MAX) begin
                            nxt_st.cfg.rot_mode = pwdata[`CFG_ROT_MODE_LSB +: 3];
                        end
                        if (pwdata[`CFG_AXIS_TYPE_BIT]) begin
                            nxt_st.cfg.rot_mode = `ROT_MODE_INDEX;
                        end
                        if (pwdata[`CFG_SHORTCUT_LSB +: 3] <= `SEL_MAX) begin
                            nxt_st.cfg.shortcut = pwdata[`CFG_SHORTCUT_LSB +: 3];
                        end
                        nxt_st.cfg.inf_stroke = pwdata[`CFG_INF_STROKE_BIT];
                    end
                    `REG_HOME_PRESET: nxt_st.home_preset = pwdata;
                    `REG_HOME_OFFSET: nxt_st.home_offset = pwdata;
                    `REG_LEN_CORR: nxt_st.len_corr = pwdata;
                    `REG_SOFT_LIM: nxt_st.soft_lim = pwdata;
                    `REG_TARGET: nxt_st.target = pwdata;
                    default: nxt_st.rdata = nxt_st.rdata;
                endcase
            end
        end

        nxt_st.tick = (st_ff.mode == S_IDLE || step_now) ? 16'h0000 : st_ff.tick + 16'h0001;
        unique case (st_ff.mode)
            S_IDLE: begin
                if (home_req) begin
                    nxt_st.mode = S_SEEK;
                    nxt_st.homed = 1'b0;
                    nxt_st.step_dir = 1'b0;
                end else if (move_req && st_ff.homed) begin
                    nxt_st.move_err = !move_ok;
                    if (move_start) begin
                        nxt_st.mode = S_MOVE;
                        nxt_st.move_delta = path_d;
                        nxt_st.remain = mag(corr_d);
                        nxt_st.step_dir = !corr_d[31];
                    end
                end
            end
            S_SEEK: begin
                if (enc_index) begin
                    nxt_st.mode = S_HOFS;
                    nxt_st.remain = mag(st_ff.home_offset);
                    nxt_st.step_dir = !st_ff.home_offset[31];
                    nxt_st.tick = 16'h0000;
                end else if (step_now) begin
                    nxt_st.step = 1'b1;
                end
            end
            S_HOFS: begin
                if (st_ff.remain == 32'h0000_0000) begin
                    nxt_st.cur_pos = st_ff.home_preset;
                    nxt_st.homed = 1'b1;
                    nxt_st.mode = S_IDLE;
                end else if (step_now) begin
                    nxt_st.step = 1'b1;
                    nxt_st.remain = st_ff.remain - 32'h0000_0001;
                end
            end
            S_MOVE: begin
                if (st_ff.remain == 32'h0000_0000) begin
                    nxt_st.cur_pos = st_ff.target;
                    nxt_st.mode = S_IDLE;
                end else if (step_now) begin
                    nxt_st.step = 1'b1;
                    nxt_st.remain = st_ff.remain - 32'h0000_0001;
                    nxt_st.cur_pos = step_pos(st_ff.cur_pos, st_ff.step_dir,
                                              rot_axis && idx_mode);
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.home_preset <= `RST_HOME_PRESET;
            st_ff.home_offset <= `RST_HOME_OFFSET;
            st_ff.len_corr <= `RST_LEN_CORR;
            st_ff.soft_lim <= `RST_SOFT_LIM;
        end else begin
            st_ff <= nxt_st;
        end
    end

    zone_compare u_zones (
        .pclk(pclk),
        .presetn(presetn),
        .position(st_ff.cur_pos),
        .zones(zone_cfg),
        .zone_hit(zone_hit),
        .zone_port(zone_port),
        .port_reserved(zone_port_reserved)
    );

    assign prdata = st_ff.rdata;
    assign pready = penable;
    assign pslverr = psel && penable && !mapped(paddr);
    assign step_pulse = st_ff.step;
    assign step_dir = st_ff.step_dir;
    assign cur_position = st_ff.cur_pos;
    assign homed = st_ff.homed;
    assign busy = (st_ff.mode != S_IDLE);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence index_seen;
        st_ff.mode == S_SEEK && enc_index;
    endsequence

    sequence offset_armed;
        st_ff.mode == S_HOFS && st_ff.remain == mag($past(st_ff.home_offset));
    endsequence

    a_preset_load: assert property ($rose(st_ff.homed) |->
        st_ff.cur_pos == $past(st_ff.home_preset))
        else $error("home position not loaded with preset");

    a_home_offset: assert property (index_seen |=> offset_armed)
        else $error("offset travel not armed after index");

    a_len_corr: assert property (move_start |=>
        st_ff.remain == mag(corrected($past(path_d), $past(st_ff.len_corr))))
        else $error("corrected travel wrong");

    a_rot_index: assert property (st_ff.cfg.axis_type |->
        st_ff.cfg.rot_mode == `ROT_MODE_INDEX && idx_mode)
        else $error("rotational axis not in index mode");

    a_mode_range: assert property (st_ff.cfg.rot_mode <= `SEL_MAX &&
        st_ff.cfg.shortcut <= `SEL_MAX)
        else $error("mode setting out of range");

    a_index_limit: assert property (idx_mode |-> soft_lim_eff == LIMIT)
        else $error("index soft limit not fixed");

    a_inf_refused: assert property ((abs_unit_fitted && !st_ff.cfg.axis_type) |->
        !inf_eff)
        else $error("infinite stroke allowed with absolute unit");

    a_shortcut_refused: assert property ((abs_unit_fitted && idx_mode && rot_axis) |->
        !shortcut_eff)
        else $error("short-cut allowed with absolute unit");

    a_shortcut_path: assert property ((move_start && shortcut_eff && rot_axis) |=>
        st_ff.move_delta <= HALF && st_ff.move_delta >= -HALF)
        else $error("short-cut path not nearest");

    a_move_snap: assert property ((st_ff.mode == S_MOVE && st_ff.remain == 32'h0) |=>
        st_ff.cur_pos == $past(st_ff.target) && !busy)
        else $error("move did not end on target");

endmodule

`default_nettype wire

//--- tb/motor_model.sv
/* Motor and encoder stand-in: counts step pulses and sends an index pulse
   once per revolution of REV steps. Assumes registered step outputs. */
`timescale 1ns/1ps
`default_nettype none
module motor_model #(
    parameter int REV = 7
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic step_pulse,
    input wire logic step_dir,
    output logic enc_index,
    output logic [31:0] steps,
    output logic [31:0] after_idx
);
    int ph_ff;
    int nxt_ph;
    always_comb begin
        if (step_dir) begin
            nxt_ph = (ph_ff == REV - 1) ? 0 : ph_ff + 1;
        end else begin
            nxt_ph = (ph_ff == 0) ? REV - 1 : ph_ff - 1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_ff <= 3;
            enc_index <= 1'b0;
            steps <= 32'h0000_0000;
            after_idx <= 32'h0000_0000;
        end else begin
            enc_index <= 1'b0;
            if (step_pulse) begin
                ph_ff <= nxt_ph;
                steps <= steps + 32'h0000_0001;
                after_idx <= after_idx + 32'h0000_0001;
                if (nxt_ph == 0) begin
                    enc_index <= 1'b1;
                    after_idx <= 32'h0000_0000;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_axis_home_zone_position_logic.sv
/* Self-checking bench of the axis position logic: APB master, motor model,
   random homing, moves and zones. Assumes STEP_CYC may be shortened to 2. */
`timescale 1ns/1ps
`default_nettype none
`include "axis_pos_params.svh"
module tb_axis_home_zone_position_logic
    import axis_pos_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, abs_unit_fitted, pready, pslverr, er;
    logic enc_index, step_pulse, step_dir, homed, busy;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, steps, after_idx, s0;
    logic signed [31:0] cur_position, t, pos;
    logic signed [31:0] zmx[4], zmn[4], tg[3];
    logic [3:0] zone_hit;
    logic [`ZONE_PORTS-1:0] zone_port, zone_port_reserved;
    int num_errors = 0, n_tests = 0, cyc = 0, pn[4], d;
    integer seed = 54;
    logic [31:0] c;

    axis_home_zone_position_logic #(.STEP_CYC(2)) DUT (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .abs_unit_fitted(abs_unit_fitted), .enc_index(enc_index), .step_pulse(step_pulse),
        .step_dir(step_dir), .cur_position(cur_position), .homed(homed), .busy(busy),
        .zone_hit(zone_hit), .zone_port(zone_port), .zone_port_reserved(zone_port_reserved));
    motor_model #(.REV(7)) partner (.pclk(pclk), .presetn(presetn), .step_pulse(step_pulse),
        .step_dir(step_dir), .enc_index(enc_index), .steps(steps), .after_idx(after_idx));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            num_errors = num_errors + 1;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests = n_tests + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dt;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dt);
        apb(1'b1, a, dt);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask
    task automatic run(input logic [31:0] cmd, input logic eb);
        s0 = steps;
        wr(`REG_CTRL, cmd);
        @(posedge pclk);
        chk("busy", 32'(eb), 32'(busy));
        for (int i = 0; i < 30000 && busy !== 1'b0; i++) @(posedge pclk);
        @(posedge pclk);
    endtask
    function automatic logic [31:0] exp_steps(input longint dd, input longint cc);
        longint s;
        s = dd + dd * cc / 64'sd1000000;
        return (s < 0) ? 32'(-s) : 32'(s);
    endfunction
    function automatic int near(input int from, input int to);
        int x;
        x = ((to - from) % 360000 + 360000) % 360000;
        return (x > 180000) ? x - 360000 : x;
    endfunction

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        abs_unit_fitted = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("hit_rst", 32'h0000_000F, 32'(zone_hit));
        rdc("preset", `REG_HOME_PRESET, `RST_HOME_PRESET);
        rdc("offset", `REG_HOME_OFFSET, `RST_HOME_OFFSET);
        rdc("corr", `REG_LEN_CORR, 32'h0000_0000);
        rdc("cfg", `REG_AXIS_CFG, 32'h0000_0000);
        for (int z = 0; z < 4; z++) begin
            rdc("zmax", `REG_ZONE_BASE + 8'(16 * z), 32'h0000_0000);
            rdc("zmin", `REG_ZONE_BASE + 8'(16 * z + 4), 32'h0000_0000);
        end
        apb(1'b0, 8'h30, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, 32'(er));
        t = $random(seed) & 32'h0000_03FF;
        wr(`REG_HOME_PRESET, t);
        wr(`REG_HOME_OFFSET, 32'h0000_0002);
        run(32'h0000_0001, 1'b1);
        chk("homed", 32'h0000_0001, 32'(homed));
        chk("home_pos", t, cur_position);
        chk("ofs_steps", 32'h0000_0002, after_idx);
        d = 1000 + ($random(seed) & 4095);
        c = $random(seed) & 32'h0000_FFFF;
        t = t + d;
        wr(`REG_LEN_CORR, c);
        wr(`REG_TARGET, t);
        run(32'h0000_0002, 1'b1);
        chk("steps", exp_steps(d, c), steps - s0);
        chk("move_pos", t, cur_position);
        zmx = '{t, t + 9, t, t - 1}; // zones set with the axis at rest
        zmn = '{t, t + 1, 0, t + 1};
        for (int z = 0; z < 4; z++) begin
            pn[z] = ($random(seed) & 32'h0000_03FF) % 900;
            wr(`REG_ZONE_BASE + 8'(16 * z), zmx[z]);
            wr(`REG_ZONE_BASE + 8'(16 * z + 4), zmn[z]);
            wr(`REG_ZONE_BASE + 8'(16 * z + 8), pn[z]);
        end
        repeat (2) @(posedge pclk);
        chk("zone_hit", 32'h0000_0005, 32'(zone_hit));
        chk("port0", 32'h0000_0001, 32'(zone_port[pn[0]]));
        chk("port2", 32'h0000_0001, 32'(zone_port[pn[2]]));
        for (int z = 0; z < 4; z++) begin
            chk("rsv", 32'h0000_0001, 32'(zone_port_reserved[pn[z]]));
        end
        wr(`REG_ZONE_BASE + 8'h04, t + 1);
        repeat (2) @(posedge pclk);
        chk("zone_left", 32'h0000_0004, 32'(zone_hit));
        wr(`REG_LEN_CORR, 32'h0000_0000);
        wr(`REG_AXIS_CFG, 32'h0000_0001);
        rdc("cfg_rot", `REG_AXIS_CFG, 32'h0000_0003);
        rdc("softlim", `REG_SOFT_LIM, `INDEX_LIMIT);
        wr(`REG_AXIS_CFG, 32'h0000_0013);
        apb(1'b0, `REG_STATUS, 32'h0000_0000);
        chk("sc_eff", 32'h0000_0001, 32'(rd[4]));
        tg = '{359000, 358000, 500};
        pos = t;
        for (int i = 0; i < 3; i++) begin
            d = near(pos, tg[i]);
            wr(`REG_TARGET, tg[i]);
            run(32'h0000_0002, 1'b1);
            chk("rot_steps", 32'(d < 0 ? -d : d), steps - s0);
            chk("rot_dir", 32'(d > 0), 32'(step_dir));
            chk("rot_pos", tg[i], cur_position);
            pos = tg[i];
        end
        wr(`REG_TARGET, 32'd360000);
        run(32'h0000_0002, 1'b0);
        chk("bad_tgt", 32'h0000_0000, steps - s0);
        apb(1'b0, `REG_STATUS, 32'h0000_0000);
        chk("move_err", 32'h0000_0001, 32'(rd[2]));
        abs_unit_fitted <= 1'b1;
        apb(1'b0, `REG_STATUS, 32'h0000_0000);
        chk("sc_abs", 32'h0000_0000, 32'(rd[4]));
        wr(`REG_AXIS_CFG, 32'h0000_0080);
        apb(1'b0, `REG_STATUS, 32'h0000_0000);
        chk("inf_abs", 32'h0000_0000, 32'(rd[5]));
        abs_unit_fitted <= 1'b0;
        apb(1'b0, `REG_STATUS, 32'h0000_0000);
        chk("inf_eff", 32'h0000_0001, 32'(rd[5]));
        chk("lin_idx", 32'h0000_0000, 32'(rd[3]));
        wr(`REG_AXIS_CFG, 32'h0000_0002);
        rdc("cfg_lin", `REG_AXIS_CFG, 32'h0000_0002);
        wr(`REG_AXIS_CFG, 32'h0000_0012);
        wr(`REG_AXIS_CFG, 32'h0000_006E);
        rdc("cfg_rsv", `REG_AXIS_CFG, 32'h0000_0012);
        tally_and_finish();
    end
endmodule
`default_nettype wire
